/* src/lmd_pkg.sv */
// constants and types for the logic/move instruction decoder
// assumes a 12-bit instruction word and a 32-entry byte file
package lmd_pkg;

   // ****************************************
   // instruction word fields
   // ****************************************
   localparam int IW_W       = 12;
   localparam int DATA_W     = 8;
   localparam int ADDR_W     = 5;
   localparam int DEST_BIT   = 5;
   localparam int ADDR_LSB   = 0;
   localparam int LIT_LSB    = 0;

   // ****************************************
   // opcode patterns
   // ****************************************
   localparam logic [5:0]  OPC_OR_ACC_INTO_REG = 6'h04;
   localparam logic [5:0]  OPC_COPY_REGISTER   = 6'h08;
   localparam logic [3:0]  OPC_LOAD_IMMEDIATE  = 4'hC;
   localparam logic [6:0]  OPC_STORE_ACC       = 7'h01;
   localparam logic [11:0] OPC_NO_OPERATION    = 12'h000;

   // ****************************************
   // reset values and timing
   // ****************************************
   localparam logic [7:0] ACC_RST       = 8'h00;
   localparam logic       ZERO_RST      = 1'b0;
   localparam int         EXEC_CYCLES   = 1;

   typedef enum logic [2:0] {
      OP_NOP,
      OP_OR,
      OP_COPY,
      OP_LDI,
      OP_STORE,
      OP_OTHER
   } lmd_op_t;

endpackage

/* src/lmd_dec_if.sv */
// carrier between the core and its decode/result unit
// assumes both ends sit on the same clock
`timescale 1ns/1ps
interface lmd_dec_if;
   import lmd_pkg::*;
   logic [IW_W-1:0]   instr;
   logic [DATA_W-1:0] acc;
   logic [DATA_W-1:0] operand;
   lmd_op_t           op;
   logic [DATA_W-1:0] result;
   logic              to_acc;
   logic              to_file;
   logic              upd_zero;

   modport core (output instr, acc, operand,
                 input  op, result, to_acc, to_file, upd_zero);
   modport dec  (input  instr, acc, operand,
                 output op, result, to_acc, to_file, upd_zero);
endinterface

/* src/lmd_decode.sv */
// purely combinational decode and result forming
// assumes operand already carries any forwarded write data
`timescale 1ns/1ps
module lmd_decode
   import lmd_pkg::*;
(
   // ****************************************
   // core side
   // ****************************************
   lmd_dec_if.dec d
);

   logic dest_file;

   always_comb begin
      dest_file  = d.instr[DEST_BIT];
      d.op       = OP_OTHER;
      d.result   = d.acc;
      d.to_acc   = 1'b0;
      d.to_file  = 1'b0;
      d.upd_zero = 1'b0;
      if (d.instr == OPC_NO_OPERATION) begin
         d.op = OP_NOP;
      end else if (d.instr[11:6] == OPC_OR_ACC_INTO_REG) begin
         d.op       = OP_OR;
         d.result   = d.acc | d.operand;
         d.to_acc   = ~dest_file;
         d.to_file  = dest_file;
         d.upd_zero = 1'b1;
      end else if (d.instr[11:6] == OPC_COPY_REGISTER) begin
         d.op       = OP_COPY;
         d.result   = d.operand;
         d.to_acc   = ~dest_file;
         d.to_file  = dest_file;
         d.upd_zero = 1'b1;
      end else if (d.instr[11:8] == OPC_LOAD_IMMEDIATE) begin
         d.op     = OP_LDI;
         d.result = d.instr[LIT_LSB +: DATA_W];
         d.to_acc = 1'b1;
      end else if (d.instr[11:5] == OPC_STORE_ACC) begin
         d.op      = OP_STORE;
         d.result  = d.acc;
         d.to_file = 1'b1;
      end
   end

endmodule

/* src/lmd_core.sv */
// logic/move instruction decoder: executes or, copy, load-immediate,
// store and no-op in one instruction cycle each
// assumes the file answers a read address with data in the same cycle
//
// Summary of operation
// - or-into-register: acc OR file byte, zero flag from the result
// - or target bit 0 writes accumulator, 1 writes the file byte
// - copy-register reads the file byte and delivers it unchanged
// - copy with target bit 0 loads accumulator, file untouched
// - copy with target bit 1 writes the value back to same byte
// - copy updates the zero flag from the moved value
// - load-immediate puts the literal in accumulator, flags unchanged
// - store writes accumulator into addressed byte, flags unchanged
`timescale 1ns/1ps
module lmd_core
   import lmd_pkg::*;
(
   // ****************************************
   // clock and reset
   // ****************************************
   input  wire logic              ref_clk,
   input  wire logic              rst,
   // ****************************************
   // fetch side
   // ****************************************
   input  wire logic              instr_valid,
   input  wire logic [IW_W-1:0]   instr_word,
   output logic                   instr_ready,
   // ****************************************
   // file register port
   // ****************************************
   output logic [ADDR_W-1:0]      file_rd_addr,
   input  wire logic [DATA_W-1:0] file_rd_data,
   output logic                   file_wr_en,
   output logic [ADDR_W-1:0]      file_wr_addr,
   output logic [DATA_W-1:0]      file_wr_data,
   // ****************************************
   // accumulator, flag and status
   // ****************************************
   output logic [DATA_W-1:0]      acc_value,
   output logic                   zero_flag,
   output logic                   exec_done,
   output logic                   unsupported
);

   typedef struct packed {
      logic [DATA_W-1:0] acc;
      logic              zero;
      logic              wr_en;
      logic [ADDR_W-1:0] wr_addr;
      logic [DATA_W-1:0] wr_data;
      logic              done;
      logic              unsup;
   } lmd_state_t;

   lmd_state_t st_reg;
   lmd_state_t st_next;
   lmd_dec_if  dec_bus ();
   logic       fwd_hit;
   logic       take;

   // ****************************************
   // operand fetch with forwarding
   // ****************************************
   // the file write lands one cycle late, so a back-to-back read of the
   // same byte would see stale data without this bypass
   assign file_rd_addr    = instr_word[ADDR_LSB +: ADDR_W];
   assign fwd_hit         = st_reg.wr_en && (st_reg.wr_addr == file_rd_addr);
   assign dec_bus.instr   = instr_word;
   assign dec_bus.acc     = st_reg.acc;
   assign dec_bus.operand = fwd_hit ? st_reg.wr_data : file_rd_data;
   assign instr_ready     = ~rst;
   assign take            = instr_valid && instr_ready;

   lmd_decode u_decode (
      .d (dec_bus.dec)
   );

   // ****************************************
   // execute
   // ****************************************
   always_comb begin
      st_next       = st_reg;
      st_next.wr_en = 1'b0;
      st_next.done  = 1'b0;
      st_next.unsup = 1'b0;
      if (take) begin
         st_next.done  = (dec_bus.op != OP_OTHER);
         st_next.unsup = (dec_bus.op == OP_OTHER);
         if (dec_bus.to_acc) begin
            st_next.acc = dec_bus.result;
         end
         if (dec_bus.to_file) begin
            st_next.wr_en   = 1'b1;
            st_next.wr_addr = file_rd_addr;
            st_next.wr_data = dec_bus.result;
         end
         if (dec_bus.upd_zero) begin
            st_next.zero = (dec_bus.result == '0);
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         st_reg.acc     <= ACC_RST;
         st_reg.zero    <= ZERO_RST;
         st_reg.wr_en   <= 1'b0;
         st_reg.wr_addr <= '0;
         st_reg.wr_data <= '0;
         st_reg.done    <= 1'b0;
         st_reg.unsup   <= 1'b0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign acc_value    = st_reg.acc;
   assign zero_flag    = st_reg.zero;
   assign file_wr_en   = st_reg.wr_en;
   assign file_wr_addr = st_reg.wr_addr;
   assign file_wr_data = st_reg.wr_data;
   assign exec_done    = st_reg.done;
   assign unsupported  = st_reg.unsup;

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   logic [DATA_W-1:0] opnd;
   logic              dbit;
   assign opnd = dec_bus.operand;
   assign dbit = instr_word[DEST_BIT];

   or_acc_a: assert property (
      take && dec_bus.op == OP_OR && !dbit |=>
         acc_value == ($past(acc_value) | $past(opnd)) && !file_wr_en)
      else $error("or to accumulator wrong");

   or_file_a: assert property (
      take && dec_bus.op == OP_OR && dbit |=>
         file_wr_en && file_wr_addr == $past(file_rd_addr)
         && file_wr_data == ($past(acc_value) | $past(opnd))
         && $stable(acc_value))
      else $error("or to file wrong");

   copy_acc_a: assert property (
      take && dec_bus.op == OP_COPY && !dbit |=>
         acc_value == $past(opnd) && !file_wr_en)
      else $error("copy to accumulator wrong");

   copy_file_a: assert property (
      take && dec_bus.op == OP_COPY && dbit |=>
         file_wr_en && file_wr_data == $past(opnd)
         && file_wr_addr == $past(file_rd_addr) && $stable(acc_value))
      else $error("copy to file wrong");

   zero_upd_a: assert property (
      take && (dec_bus.op == OP_COPY || dec_bus.op == OP_OR) |=>
         zero_flag == ($past(dec_bus.result) == 8'h00))
      else $error("zero flag wrong");

   load_imm_a: assert property (
      take && dec_bus.op == OP_LDI |=>
         acc_value == $past(instr_word[7:0]) && $stable(zero_flag)
         && !file_wr_en)
      else $error("load immediate wrong");

   store_acc_a: assert property (
      take && dec_bus.op == OP_STORE |=>
         file_wr_en && file_wr_data == $past(acc_value)
         && file_wr_addr == $past(instr_word[4:0])
         && $stable(zero_flag) && $stable(acc_value))
      else $error("store wrong");

   no_op_a: assert property (
      take && instr_word == OPC_NO_OPERATION |=>
         $stable(acc_value) && $stable(zero_flag) && !file_wr_en
         && exec_done)
      else $error("no-op changed state");

   one_cycle_a: assert property (
      take && dec_bus.op != OP_OTHER |=> exec_done ##1 !exec_done
         || (exec_done && $past(take)))
      else $error("instruction not single cycle");

   // ****************************************
   // quiet cycles and value paths
   // ****************************************

   copy_value_a: assert property (
      take && dec_bus.op == OP_COPY |=>
         (file_wr_en ? file_wr_data : acc_value) == $past(opnd))
      else $error("copy value altered");

   or_zero_a: assert property (
      take && dec_bus.op == OP_OR |=>
         zero_flag == (($past(acc_value) | $past(opnd)) == 8'h00))
      else $error("or zero flag wrong");

   // nothing may move without a taken word, so an idle slot never leaks
   idle_quiet_a: assert property (
      !take |=> !exec_done && !unsupported && !file_wr_en
         && $stable(acc_value) && $stable(zero_flag))
      else $error("state moved while idle");

   done_cause_a: assert property (
      exec_done || unsupported |-> $past(take))
      else $error("result pulse without a taken word");

   other_op_a: assert property (
      take && dec_bus.op == OP_OTHER |=> unsupported && !exec_done
         && !file_wr_en && $stable(acc_value) && $stable(zero_flag))
      else $error("unsupported word changed state");

   // outside reset the core never stalls, so every word offered then is taken at once
   no_stall_a: assert property (instr_ready)
      else $error("fetch stalled");

   cover_or_file_c: cover property (
      take && dec_bus.op == OP_OR && dbit);
   cover_zero_test_c: cover property (
      take && dec_bus.op == OP_COPY && dbit ##1 zero_flag);
   cover_ldi_store_c: cover property (
      take && dec_bus.op == OP_LDI ##1 take && dec_bus.op == OP_STORE);
   cover_forward_c: cover property (take && fwd_hit);
   cover_nop_c: cover property (
      take && dec_bus.op == OP_NOP);

endmodule

/* sim/lmd_regfile.sv */
// file register model: 32 bytes, same-cycle read, write at edge
// assumes the core forwards its own pending write
`timescale 1ns/1ps
module lmd_regfile
   import lmd_pkg::*;
(
   // ****************************************
   // clock
   // ****************************************
   input  wire logic              ref_clk,
   // ****************************************
   // file port
   // ****************************************
   input  wire logic [ADDR_W-1:0] rd_addr,
   output logic [DATA_W-1:0]      rd_data,
   input  wire logic              wr_en,
   input  wire logic [ADDR_W-1:0] wr_addr,
   input  wire logic [DATA_W-1:0] wr_data
);
   logic [DATA_W-1:0] mem [32];
   initial begin
      for (int i = 0; i < 32; i++) begin
         mem[i] = 8'(i) ^ 8'h5A;
      end
   end
   assign rd_data = mem[rd_addr];
   always @(posedge ref_clk) begin
      if (wr_en === 1'b1) begin
         mem[wr_addr] <= wr_data;
      end
   end
endmodule

/* sim/testbench.sv */
// self-checking bench for the logic/move decoder
// assumes one clock, sync reset, file model beside the core
`timescale 1ns/1ps
module testbench
   import lmd_pkg::*;
;
   typedef struct {
      logic [7:0] acc;
      logic       z;
      logic       we;
      logic [4:0] wa;
      logic [7:0] wd;
      logic       un;
   } lmd_exp_t;
   logic        ref_clk, rst, instr_valid, instr_ready, file_wr_en;
   logic        zero_flag, exec_done, unsupported;
   logic [11:0] instr_word;
   logic [4:0]  file_rd_addr, file_wr_addr;
   logic [7:0]  file_rd_data, file_wr_data, acc_value, racc;
   logic [7:0]  mir [32];
   logic        rz;
   lmd_exp_t    q [$];
   int          n_fail, compares, seed;
   lmd_core uut (.ref_clk(ref_clk), .rst(rst), .instr_valid(instr_valid),
      .instr_word(instr_word), .instr_ready(instr_ready),
      .file_rd_addr(file_rd_addr), .file_rd_data(file_rd_data),
      .file_wr_en(file_wr_en), .file_wr_addr(file_wr_addr),
      .file_wr_data(file_wr_data), .acc_value(acc_value),
      .zero_flag(zero_flag), .exec_done(exec_done),
      .unsupported(unsupported));
   lmd_regfile fm (.ref_clk(ref_clk), .rd_addr(file_rd_addr),
      .rd_data(file_rd_data), .wr_en(file_wr_en), .wr_addr(file_wr_addr),
      .wr_data(file_wr_data));
   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end
   task automatic cmp(string what, logic [7:0] got, logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic end_of_test();
      $display("compares %0d mismatches %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // reference step; mirror updates at once, like the core's forwarding
   task automatic issue(logic [11:0] w);
      lmd_exp_t   e;
      logic [4:0] f;
      logic [7:0] r;
      f = w[4:0];
      e = '{acc: 8'h00, z: 1'b0, we: 1'b0, wa: f, wd: 8'h00, un: 1'b0};
      if (w[11:6] == OPC_OR_ACC_INTO_REG || w[11:6] == OPC_COPY_REGISTER)
      begin
         r = (w[11:6] == OPC_COPY_REGISTER) ? mir[f] : (racc | mir[f]);
         rz = (r == 8'h00);
         if (w[5]) begin
            mir[f] = r;
            e.we = 1'b1;
            e.wd = r;
         end else racc = r;
      end else if (w[11:8] == OPC_LOAD_IMMEDIATE) racc = w[7:0];
      else if (w[11:5] == OPC_STORE_ACC) begin
         mir[f] = racc;
         e.we = 1'b1;
         e.wd = racc;
      end else if (w != OPC_NO_OPERATION) e.un = 1'b1;
      e.acc = racc;
      e.z = rz;
      q.push_back(e);
      @(negedge ref_clk);
      instr_valid = 1'b1;
      instr_word = w;
   endtask
   function automatic logic [11:0] rnd_word(int k);
      logic [7:0] v;
      v = 8'($random(seed));
      case (k)
         0: return {OPC_OR_ACC_INTO_REG, v[5:0]};
         1: return {OPC_COPY_REGISTER, v[5:0]};
         2: return {OPC_LOAD_IMMEDIATE, v[1:0] == 2'h0 ? 8'h00 : v};
         3: return {OPC_STORE_ACC, v[4:0]};
         4: return OPC_NO_OPERATION;
         default: return v[0] ? 12'hD35 : {4'h3, v};
      endcase
   endfunction
   // monitor: every done or unsupported pulse consumes one note
   always @(posedge ref_clk) begin
      #1;
      if (exec_done === 1'b1 || unsupported === 1'b1) begin
         if (q.size() == 0) cmp("extra result", 8'h01, 8'h00);
         else begin
            lmd_exp_t e;
            e = q.pop_front();
            cmp("acc", acc_value, e.acc);
            cmp("zero", {7'h0, zero_flag}, {7'h0, e.z});
            cmp("wr_en", {7'h0, file_wr_en}, {7'h0, e.we});
            if (e.we) cmp("wr_addr", 8'(file_wr_addr), 8'(e.wa));
            if (e.we) cmp("wr_data", file_wr_data, e.wd);
            cmp("unsup", {7'h0, unsupported}, {7'h0, e.un});
         end
      end
   end
   initial begin
      #20000;
      n_fail++;
      end_of_test();
   end
   initial begin
      n_fail = 0;
      compares = 0;
      seed = 33;
      rst = 1'b1;
      instr_valid = 1'b0;
      instr_word = 12'h000;
      racc = ACC_RST;
      rz = ZERO_RST;
      repeat (3) @(negedge ref_clk);
      rst = 1'b0;
      @(negedge ref_clk);
      cmp("reset acc", acc_value, ACC_RST);
      cmp("ready", {7'h0, instr_ready}, 8'h01);
      // fill every byte so later reads are known
      for (int i = 0; i < 32; i++) begin
         issue({OPC_LOAD_IMMEDIATE, 8'($random(seed))});
         issue({OPC_STORE_ACC, 5'(i)});
      end
      $display("fill test done");
      // zero test by copying a cleared byte onto itself
      issue(12'hC00);
      issue(12'h029);
      issue(12'hCFF);
      issue(12'h229);
      issue(12'h209);
      $display("zero test done");
      for (int n = 0; n < 300; n++) begin
         issue(rnd_word(($random(seed) & 7) % 6));
      end
      @(negedge ref_clk);
      instr_valid = 1'b0;
      $display("random mix test done");
      // mid-run reset: core state returns, the file keeps its bytes
      rst = 1'b1;
      @(negedge ref_clk);
      cmp("ready in reset", {7'h0, instr_ready}, 8'h00);
      cmp("acc in reset", acc_value, ACC_RST);
      cmp("zero in reset", {7'h0, zero_flag}, {7'h0, ZERO_RST});
      rst = 1'b0;
      racc = ACC_RST;
      rz = ZERO_RST;
      issue(12'h10A);
      issue(12'h000);
      @(negedge ref_clk);
      instr_valid = 1'b0;
      repeat (4) @(negedge ref_clk);
      cmp("pending", 8'(q.size()), 8'h00);
      $display("reset test done");
      end_of_test();
   end
endmodule
